// *** logic/sfrps_pkg.sv ***
// Constants shared by the page stack readout block
package sfrps_pkg;
   // =========================================================
   // Special function register addresses
   localparam logic [7:0] ADDR_ACTIVE_PAGE     = 8'ha7;
   localparam logic [7:0] ADDR_PAGE_CONTROL    = 8'hcf;
   localparam logic [7:0] ADDR_PAGE_STACK_VIEW = 8'hd3;
   // =========================================================
   // Reserved locations, both pages
   localparam logic [7:0] ADDR_RSVD_A = 8'hb0;
   localparam logic [7:0] ADDR_RSVD_B = 8'hb4;
   localparam logic [7:0] ADDR_RSVD_C = 8'he5;
   localparam logic [7:0] ADDR_RSVD_D = 8'hf5;
   // Reserved on every page except page F
   localparam logic [7:0] ADDR_RSVD_P0_A = 8'had;
   localparam logic [7:0] ADDR_RSVD_P0_B = 8'hae;
   // =========================================================
   // Pages
   localparam logic [7:0] PAGE_0 = 8'h00;
   localparam logic [7:0] PAGE_F = 8'h0f;
   // =========================================================
   // Bit-addressable low nibbles
   localparam logic [3:0] BIT_NIBBLE_0 = 4'h0;
   localparam logic [3:0] BIT_NIBBLE_8 = 4'h8;
   // =========================================================
   // Page control fields
   localparam int         IDX_LSB         = 4;
   localparam int         IDX_MSB         = 6;
   localparam int         EN_BIT          = 0;
   localparam logic [2:0] IDX_TOP         = 3'h0;
   localparam logic [2:0] IDX_BOTTOM      = 3'h4;
   localparam int         STACK_LEVELS    = 5;
   localparam logic [7:0] RESET_PAGE      = 8'h00;
   localparam logic [7:0] RESET_STACK     = 8'h00;
   localparam logic [2:0] RESET_IDX       = 3'h0;
   localparam logic       RESET_AUTO_EN   = 1'b1;
endpackage

// *** logic/sfrps_stack_if.sv ***
// Carrier between the readout top and the stack storage
`timescale 1ns/1ps
interface sfrps_stack_if;
   logic       push;
   logic       pop;
   logic [7:0] push_data;
   logic [2:0] rd_level;
   logic [7:0] rd_data;
   logic [7:0] top_level;

   modport ctrl
   (
      output push,
      output pop,
      output push_data,
      output rd_level,
      input  rd_data,
      input  top_level
   );
   modport mem
   (
      input  push,
      input  pop,
      input  push_data,
      input  rd_level,
      output rd_data,
      output top_level
   );
endinterface

// *** logic/sfrps_stack_mem.sv ***
// Storage for the lower levels of the page stack
`timescale 1ns/1ps
module sfrps_stack_mem #(
   parameter int DEPTH = 4
) (
   input  wire logic   i_clk_sys,
   input  wire logic   i_rst_n,
   sfrps_stack_if.mem  stk
);
   logic [7:0] level_reg [DEPTH];
   logic [7:0] rd_data_reg;

   // =========================================================
   // Push shifts down, pop shifts up; bottom refills with zero
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            level_reg[i] <= sfrps_pkg::RESET_STACK;
         end
      end
      else if (stk.push)
      begin
         level_reg[0] <= stk.push_data;
         for (int i = 1; i < DEPTH; i++)
         begin
            level_reg[i] <= level_reg[i-1];
         end
      end
      else if (stk.pop)
      begin
         for (int i = 0; i < DEPTH - 1; i++)
         begin
            level_reg[i] <= level_reg[i+1];
         end
         level_reg[DEPTH-1] <= sfrps_pkg::RESET_STACK;
      end
   end

   // =========================================================
   // Registered read; level 1 is word 0
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rd_data_reg <= sfrps_pkg::RESET_STACK;
      end
      else if (stk.rd_level >= 3'h1 && stk.rd_level <= 3'(DEPTH))
      begin
         rd_data_reg <= level_reg[2'(stk.rd_level - 3'h1)];
      end
      else
      begin
         rd_data_reg <= sfrps_pkg::RESET_STACK;
      end
   end

   assign stk.rd_data   = rd_data_reg;
   assign stk.top_level = level_reg[0];
endmodule

// *** logic/sfrps_readout.sv ***
// Page register, page control and page stack view with paged decode
`timescale 1ns/1ps
// Summary of operation
// - Stack view returns level chosen by index
// - Stack view is read-only; writes ignored
// - Stack view decodes at 0xd3 on page F only
// - Bit operations only where low nibble 0/8
// - Shared registers ignore active page
// - Only listed reserved addresses flagged reserved
// - Index 0 top, 1..4 lower, 5..7 invalid
// - Auto paging pushes on entry, pops on return
module sfrps_readout (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_rd,
   input  wire logic       i_sfr_wr,
   input  wire logic [7:0] i_sfr_wdata,
   input  wire logic       i_bit_op,
   input  wire logic       i_isr_enter,
   input  wire logic [7:0] i_isr_page,
   input  wire logic       i_isr_return,
   output logic      [7:0] o_sfr_rdata,
   output logic            o_sfr_hit,
   output logic            o_reserved,
   output logic            o_bit_ok,
   output logic            o_bit_err,
   output logic      [7:0] o_active_page
);
   typedef enum logic [1:0] {
      SFRPS_SEL_NONE,
      SFRPS_SEL_PAGE,
      SFRPS_SEL_CTRL,
      SFRPS_SEL_VIEW
   } sfrps_sel_t;

   logic [7:0] active_page_reg;
   logic [7:0] active_page_next;
   logic [2:0] level_idx_reg;
   logic       auto_en_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       hit_reg;
   logic       rsvd_reg;
   logic       bit_ok_reg;
   logic       bit_err_reg;
   logic       access;
   logic       do_push;
   logic       do_pop;
   sfrps_sel_t sel;

   sfrps_stack_if stk ();

   // =========================================================
   // Decode helpers
   function automatic sfrps_sel_t decode(input logic [7:0] addr, input logic [7:0] page);
      sfrps_sel_t s;
      s = SFRPS_SEL_NONE;
      if (addr == sfrps_pkg::ADDR_ACTIVE_PAGE)
      begin
         s = SFRPS_SEL_PAGE;
      end
      else if (addr == sfrps_pkg::ADDR_PAGE_CONTROL)
      begin
         s = SFRPS_SEL_CTRL;
      end
      else if (addr == sfrps_pkg::ADDR_PAGE_STACK_VIEW && page == sfrps_pkg::PAGE_F)
      begin
         s = SFRPS_SEL_VIEW;
      end
      return s;
   endfunction

   function automatic logic is_reserved(input logic [7:0] addr, input logic [7:0] page);
      logic r;
      r = (addr == sfrps_pkg::ADDR_RSVD_A) || (addr == sfrps_pkg::ADDR_RSVD_B)
        || (addr == sfrps_pkg::ADDR_RSVD_C) || (addr == sfrps_pkg::ADDR_RSVD_D);
      if (page != sfrps_pkg::PAGE_F)
      begin
         r = r || (addr == sfrps_pkg::ADDR_RSVD_P0_A) || (addr == sfrps_pkg::ADDR_RSVD_P0_B);
      end
      return r;
   endfunction

   function automatic logic is_bit_addr(input logic [7:0] addr);
      return (addr[3:0] == sfrps_pkg::BIT_NIBBLE_0) || (addr[3:0] == sfrps_pkg::BIT_NIBBLE_8);
   endfunction

   assign sel     = decode(i_sfr_addr, active_page_reg);
   assign access  = i_sfr_rd | i_sfr_wr | i_bit_op;
   // Entry wins over return if both arrive together; core never does that
   assign do_push = auto_en_reg & i_isr_enter;
   assign do_pop  = auto_en_reg & i_isr_return & ~i_isr_enter;

   // =========================================================
   // Stack storage
   assign stk.push      = do_push;
   assign stk.pop       = do_pop;
   assign stk.push_data = active_page_reg;
   assign stk.rd_level  = level_idx_reg;

   sfrps_stack_mem #(
      .DEPTH (sfrps_pkg::STACK_LEVELS - 1)
   ) u_stack (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .stk       (stk)
   );

   // =========================================================
   // Active page: interrupt paging beats a software write
   always_comb
   begin
      active_page_next = active_page_reg;
      if (do_push)
      begin
         active_page_next = i_isr_page;
      end
      else if (do_pop)
      begin
         active_page_next = stk.top_level;
      end
      else if (i_sfr_wr && sel == SFRPS_SEL_PAGE)
      begin
         active_page_next = i_sfr_wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         active_page_reg <= sfrps_pkg::RESET_PAGE;
      end
      else
      begin
         active_page_reg <= active_page_next;
      end
   end

   // =========================================================
   // Page control; reserved bits are not stored
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         level_idx_reg <= sfrps_pkg::RESET_IDX;
         auto_en_reg   <= sfrps_pkg::RESET_AUTO_EN;
      end
      else if (i_sfr_wr && sel == SFRPS_SEL_CTRL)
      begin
         level_idx_reg <= i_sfr_wdata[sfrps_pkg::IDX_MSB:sfrps_pkg::IDX_LSB];
         auto_en_reg   <= i_sfr_wdata[sfrps_pkg::EN_BIT];
      end
   end

   // =========================================================
   // Read mux; the view has no write path at all
   always_comb
   begin
      rdata_next = 8'h00;
      case (sel)
         SFRPS_SEL_PAGE:
         begin
            rdata_next = active_page_reg;
         end
         SFRPS_SEL_CTRL:
         begin
            rdata_next = 8'h00;
            rdata_next[sfrps_pkg::IDX_MSB:sfrps_pkg::IDX_LSB] = level_idx_reg;
            rdata_next[sfrps_pkg::EN_BIT] = auto_en_reg;
         end
         SFRPS_SEL_VIEW:
         begin
            // Lower levels come from the stack's registered read
            if (level_idx_reg == sfrps_pkg::IDX_TOP)
            begin
               rdata_next = active_page_reg;
            end
            else if (level_idx_reg <= sfrps_pkg::IDX_BOTTOM)
            begin
               rdata_next = stk.rd_data;
            end
            else
            begin
               rdata_next = 8'h00;
            end
         end
         SFRPS_SEL_NONE:
         begin
            rdata_next = 8'h00;
         end
         default:
         begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // =========================================================
   // Answer registers, one cycle after the access
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_reg   <= 8'h00;
         hit_reg     <= 1'b0;
         rsvd_reg    <= 1'b0;
         bit_ok_reg  <= 1'b0;
         bit_err_reg <= 1'b0;
      end
      else
      begin
         rdata_reg   <= i_sfr_rd ? rdata_next : 8'h00;
         hit_reg     <= access && sel != SFRPS_SEL_NONE;
         rsvd_reg    <= access && is_reserved(i_sfr_addr, active_page_reg);
         bit_ok_reg  <= i_bit_op && is_bit_addr(i_sfr_addr);
         bit_err_reg <= i_bit_op && !is_bit_addr(i_sfr_addr);
      end
   end

   assign o_sfr_rdata   = rdata_reg;
   assign o_sfr_hit     = hit_reg;
   assign o_reserved    = rsvd_reg;
   assign o_bit_ok      = bit_ok_reg;
   assign o_bit_err     = bit_err_reg;
   assign o_active_page = active_page_reg;
endmodule

// *** testbench/sfrps_readout_chk.sv ***
// Port checker for the page stack readout
`timescale 1ns/1ps
module sfrps_readout_chk (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_n,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_sfr_rd,
   input wire logic       i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic       i_bit_op,
   input wire logic       i_isr_enter,
   input wire logic       i_isr_return,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic       o_sfr_hit,
   input wire logic       o_reserved,
   input wire logic       o_bit_ok,
   input wire logic       o_bit_err,
   input wire logic [7:0] o_active_page
);
   // ========================================
   // Helpers
   logic nib;
   logic acc;
   logic rsv;
   logic pwr;
   logic isr;
   assign nib = i_sfr_addr[3:0] == 4'h0 || i_sfr_addr[3:0] == 4'h8;
   assign acc = i_sfr_rd || i_sfr_wr || i_bit_op;
   assign rsv = i_sfr_addr inside {8'hb0, 8'hb4, 8'he5, 8'hf5};
   assign pwr = i_sfr_wr && i_sfr_addr == 8'ha7;
   assign isr = i_isr_enter || i_isr_return;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_view;
      i_sfr_rd && i_sfr_addr == 8'hd3;
   endsequence
   // ========================================
   // Assertions
   AST_VIEW_F: assert property (s_view ##0 o_active_page == 8'h0f |=> o_sfr_hit)
      else $error("view missed on page F");
   AST_VIEW_P0: assert property (s_view ##0 o_active_page != 8'h0f |=> !o_sfr_hit
      && o_sfr_rdata == 8'h00) else $error("view seen on page 0");
   AST_NO_RD: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
      else $error("data without read");
   AST_BIT_OK: assert property (i_bit_op && nib |=> o_bit_ok && !o_bit_err)
      else $error("bit op refused");
   AST_BIT_ERR: assert property (i_bit_op && !nib |=> o_bit_err && !o_bit_ok)
      else $error("bit op accepted");
   AST_BIT_IDLE: assert property (!i_bit_op |=> !(o_bit_ok || o_bit_err))
      else $error("bit flag without op");
   AST_RSVD: assert property (acc && rsv |=> o_reserved && !o_sfr_hit)
      else $error("reserved not flagged");
   AST_PAGE_HOLD: assert property (!isr && !pwr |=> $stable(o_active_page))
      else $error("page moved");
   AST_PAGE_WR: assert property (pwr && !isr |=> o_active_page == $past(i_sfr_wdata))
      else $error("page write lost");
endmodule
bind sfrps_readout sfrps_readout_chk u_chk (.i_clk_sys, .i_rst_n, .i_sfr_addr, .i_sfr_rd,
   .i_sfr_wr, .i_sfr_wdata, .i_bit_op, .i_isr_enter, .i_isr_return, .o_sfr_rdata,
   .o_sfr_hit, .o_reserved, .o_bit_ok, .o_bit_err, .o_active_page);

// *** testbench/sfr_page_stack_readout_tb.sv ***
// Self-checking bench for the page stack readout
`timescale 1ns/1ps
module sfr_page_stack_readout_tb;
   logic       clk;
   logic       rst_n;
   logic [7:0] addr;
   logic       rd;
   logic       wr;
   logic [7:0] wdata;
   logic       bop;
   logic       ien;
   logic [7:0] ipage;
   logic       iret;
   logic [7:0] rdata;
   logic       hit;
   logic       rsv;
   logic       bok;
   logic       berr;
   logic [7:0] apage;
   logic [7:0] q_d;
   logic [3:0] q_f;
   int         err_total;
   int         compares;
   sfrps_readout u_dut (
      .i_clk_sys    (clk),
      .i_rst_n      (rst_n),
      .i_sfr_addr   (addr),
      .i_sfr_rd     (rd),
      .i_sfr_wr     (wr),
      .i_sfr_wdata  (wdata),
      .i_bit_op     (bop),
      .i_isr_enter  (ien),
      .i_isr_page   (ipage),
      .i_isr_return (iret),
      .o_sfr_rdata  (rdata),
      .o_sfr_hit    (hit),
      .o_reserved   (rsv),
      .o_bit_ok     (bok),
      .o_bit_err    (berr),
      .o_active_page(apage)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ========================================
   // Shared tasks
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Extra idle cycle lets registered stack reads settle
   task automatic acc(input logic r, w, b, input logic [7:0] a, d);
      {rd, wr, bop, addr, wdata} = {r, w, b, a, d};
      @(negedge clk);
      {rd, wr, bop} = 3'h0;
      {q_d, q_f} = {rdata, hit, rsv, bok, berr};
      @(negedge clk);
   endtask
   task automatic isr(input logic e, r, input logic [7:0] p);
      {ien, iret, ipage} = {e, r, p};
      @(negedge clk);
      {ien, iret} = 2'h0;
      @(negedge clk);
   endtask
   task automatic view(input logic [2:0] i, input logic [7:0] exp);
      acc(0, 1, 0, 8'hcf, {1'b0, i, 4'h1});
      acc(1, 0, 0, 8'hd3, 8'h00);
      chk("view", q_d, exp);
   endtask
   // ========================================
   // Scenarios
   task automatic t_reset();
      chk("page", apage, 8'h00);
      acc(1, 0, 0, 8'hd3, 8'h00);
      chk("p0 hit", {7'h0, q_f[3]}, 8'h00);
      acc(0, 1, 0, 8'ha7, 8'h0f);
      for (int i = 0; i < 5; i++)
         view(i[2:0], i == 0 ? 8'h0f : 8'h00);
      chk("pf hit", {7'h0, q_f[3]}, 8'h01);
   endtask
   task automatic t_push();
      logic [7:0] exp [8];
      exp = '{8'h0f, 8'h25, 8'h24, 8'h23, 8'h22, 8'h00, 8'h00, 8'h00};
      for (int i = 1; i < 6; i++)
      begin
         acc(0, 1, 0, 8'ha7, 8'h20 + 8'(i));
         isr(1, 0, 8'h0f);
         chk("push page", apage, 8'h0f);
      end
      for (int i = 0; i < 8; i++)
         view(i[2:0], exp[i]);
      acc(0, 1, 0, 8'hd3, 8'hff);
      view(3'h1, 8'h25);
   endtask
   task automatic t_pop();
      logic [7:0] exp [5];
      exp = '{8'h25, 8'h24, 8'h23, 8'h22, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         isr(0, 1, 8'h00);
         chk("pop page", apage, exp[i]);
      end
      acc(0, 1, 0, 8'hcf, 8'h00);
      isr(1, 0, 8'h0f);
      chk("no push", apage, 8'h00);
      isr(0, 1, 8'h00);
      chk("auto off", apage, 8'h00);
   endtask
   task automatic t_map();
      logic [7:0] ra [4];
      ra = '{8'hb0, 8'hb4, 8'he5, 8'hf5};
      for (int n = 0; n < 16; n++)
      begin
         acc(0, 0, 1, {4'h9, n[3:0]}, 8'h00);
         chk("bit", {6'h0, q_f[1:0]}, (n == 0 || n == 8) ? 8'h02 : 8'h01);
      end
      for (int p = 0; p < 2; p++)
      begin
         acc(0, 1, 0, 8'ha7, p == 0 ? 8'h00 : 8'h0f);
         acc(1, 0, 0, 8'hcf, 8'h00);
         chk("ctrl", q_d, 8'h00);
         chk("ctrl hit", {7'h0, q_f[3]}, 8'h01);
         foreach (ra[i])
         begin
            acc(1, 0, 0, ra[i], 8'h00);
            chk("rsvd", {7'h0, q_f[2]}, 8'h01);
         end
         acc(1, 0, 0, 8'had, 8'h00);
         chk("rsvd p0", {7'h0, q_f[2]}, p == 0 ? 8'h01 : 8'h00);
      end
   endtask
   // Two pages pushed, then reset in mid-run must clear them
   task automatic t_rerun();
      acc(0, 1, 0, 8'hcf, 8'h01);
      acc(0, 1, 0, 8'ha7, 8'h33);
      isr(1, 0, 8'h0f);
      isr(1, 1, 8'h44);
      chk("enter wins", apage, 8'h44);
      rst_n = 1'b0;
      @(negedge clk);
      chk("rst page", apage, 8'h00);
      rst_n = 1'b1;
      @(negedge clk);
      acc(0, 1, 0, 8'ha7, 8'h0f);
      view(3'h1, 8'h00);
      view(3'h2, 8'h00);
   endtask
   // ========================================
   // Run control
   task automatic end_of_test();
      $display("checks %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #20000;
      err_total++;
      end_of_test();
   end
   initial
   begin
      {rst_n, rd, wr, bop, ien, iret, addr, wdata, ipage} = '0;
      err_total = 0;
      compares = 0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_reset();
      t_push();
      t_pop();
      t_map();
      t_rerun();
      end_of_test();
   end
endmodule
